/* hw/adtd_ctrl.sv */
// converter control and output registers with an AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adtd_regs.svh"
module adtd_ctrl
    import adtd_pkg::*;
#(
    parameter int DAC_SETTLE_CYC = `ADTD_DAC_SETTLE_CYC,
    parameter int TRIG_FILT_CYC  = `ADTD_TRIG_MIN_CYC / 2
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        trig_n,
    input  wire logic        bipolar_range,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_result,
    output logic             conv_start,
    output logic      [5:0]  adc_chan,
    output logic      [3:0]  adc_mode,
    output logic             settle_start,
    output logic             dac0_loopback_select,
    output logic             dac1_loopback_select,
    output logic      [11:0] dac0_code,
    output logic      [11:0] dac1_code,
    output logic             dac0_load,
    output logic             dac1_load,
    output logic             outputs_online,
    output logic             irq
);
    localparam int SW = $clog2(DAC_SETTLE_CYC + 1);

    // word decode: the byte lanes of a register alias to it
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        return {a[7:2], 2'b00} == off;
    endfunction

    // offset binary to two's complement: invert the sign bit and extend it
    function automatic logic [15:0] fmt_result(input logic [11:0] r, input logic sgn, input logic bip);
        logic [15:0] v;
        v = {4'h0, r};
        if (sgn && bip) begin
            v = {{4{~r[11]}}, ~r[11], r[10:0]};
        end
        return v;
    endfunction

    // pin synchronisation
    logic [1:0] pin_s;
    logic       trig_fire;

    adtd_sync #(
        .W       (2),
        .RST_VAL (2'b10)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .ce    (ce),
        .d     ({trig_n, bipolar_range}),
        .q     (pin_s)
    );

    // the filter passes only lows long enough to be a real pulse
    adtd_trig_det #(
        .FILT_CYC (TRIG_FILT_CYC)
    ) u_trig (
        .clk      (hclk),
        .rst_n    (hresetn),
        .ce       (ce),
        .trig_low (~pin_s[1]),
        .fire     (trig_fire)
    );

    // range strap is a slow level, read through the synchroniser
    wire bipolar = pin_s[0];

    // state
    adtd_cword_t      cword_q;
    adtd_dphase_t     dph_q;
    adtd_conv_state_t state_q;
    logic [31:0]      hrdata_q;
    logic             conv_start_q;
    logic [11:0]      result_q;
    logic             ready_q;
    logic [11:0]      dac0_q;
    logic [11:0]      dac1_q;
    logic             dac0_load_q;
    logic             dac1_load_q;
    logic [SW-1:0]    settle_q;
    logic             online_q;
    logic             loop0_q;
    logic             loop1_q;
    logic [1:0]       irq_st_q;
    logic [1:0]       irq_mask_q;
    logic             irq_q;
    logic             hreadyout_q;
    logic             hresp_q;

    // address phase
    wire       acc      = hsel & hready & htrans[1];
    wire [7:0] aa       = haddr[7:0];
    wire       rd_acc   = acc & ~hwrite;
    wire       rd_adc   = rd_acc & is_reg(aa, `ADTD_OFF_ADC_DATA);

    // data phase writes
    wire       wr       = dph_q.write_en;
    wire       wr_cword = wr & is_reg(dph_q.addr, `ADTD_OFF_CWORD);
    wire       wr_dac0  = wr & is_reg(dph_q.addr, `ADTD_OFF_DAC0);
    wire       wr_dac1  = wr & is_reg(dph_q.addr, `ADTD_OFF_DAC1);
    wire       wr_onl   = wr & is_reg(dph_q.addr, `ADTD_OFF_ONLINE);
    wire       wr_ist   = wr & is_reg(dph_q.addr, `ADTD_OFF_IRQ_STATUS);
    wire       wr_imsk  = wr & is_reg(dph_q.addr, `ADTD_OFF_IRQ_MASK);

    // reserved bits are masked on the way in
    wire adtd_cword_t cword_wv = adtd_cword_t'(hwdata[15:0] & `ADTD_CWORD_WMASK);

    // conversion start sources
    wire       idle     = (state_q == ADTD_IDLE);
    wire       ext_req  = trig_fire & cword_q.ext_trig_en;
    wire       sw_req   = wr_cword & cword_wv.sw_convert_en & ~cword_wv.ext_trig_en;
    wire       start    = idle & (ext_req | sw_req);
    wire       done_evt = (state_q == ADTD_BUSY) & conv_done;
    wire       trig_lost = ext_req & ~idle;

    // status and interrupt next values, set beats clear
    wire       ready_d  = done_evt | (ready_q & ~rd_adc);
    wire [1:0] irq_ev   = {trig_lost, done_evt};
    wire [1:0] irq_clr  = wr_ist ? hwdata[1:0] : 2'b00;
    wire [1:0] irq_st_d = irq_ev | (irq_st_q & ~irq_clr);

    wire [15:0] adc_word = fmt_result(result_q, cword_q.signed_format_select, bipolar);
    wire        settling = (settle_q != '0);

    // read decode, one select per register
    wire       sel_cword = is_reg(aa, `ADTD_OFF_CWORD);
    wire       sel_stat  = is_reg(aa, `ADTD_OFF_STATUS);
    wire       sel_dac0  = is_reg(aa, `ADTD_OFF_DAC0);
    wire       sel_dac1  = is_reg(aa, `ADTD_OFF_DAC1);
    wire       sel_adc   = is_reg(aa, `ADTD_OFF_ADC_DATA);
    wire       sel_onl   = is_reg(aa, `ADTD_OFF_ONLINE);
    wire       sel_ist   = is_reg(aa, `ADTD_OFF_IRQ_STATUS);
    wire       sel_imsk  = is_reg(aa, `ADTD_OFF_IRQ_MASK);

    wire [31:0] rd_val =
        sel_cword ? {16'h0000, cword_q} :
        sel_stat  ? {28'h0000000, online_q, settling, ~idle, ready_q} :
        sel_dac0  ? {20'h00000, dac0_q} :
        sel_dac1  ? {20'h00000, dac1_q} :
        sel_adc   ? {16'h0000, adc_word} :
        sel_onl   ? {31'h0, online_q} :
        sel_ist   ? {30'h0, irq_st_q} :
        sel_imsk  ? {30'h0, irq_mask_q} :
                    32'h00000000;

    wire [3:0] mode_nx  = wr_cword ? cword_wv.mode : cword_q.mode;

    // bus slave: zero wait, always OKAY, answer flags held in flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q       <= '0;
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else if (ce) begin
            dph_q.write_en <= acc & hwrite;
            dph_q.addr     <= aa;
            hrdata_q       <= rd_acc ? rd_val : 32'h00000000;
            hreadyout_q    <= 1'b1;
            hresp_q        <= 1'b0;
        end
    end

    // control word and on-line switch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cword_q  <= adtd_cword_t'(`ADTD_CWORD_RESET);
            online_q <= 1'b0;
            loop0_q  <= 1'b0;
            loop1_q  <= 1'b0;
        end else if (ce) begin
            if (wr_cword) begin
                cword_q <= cword_wv;
            end
            if (wr_onl) begin
                online_q <= hwdata[0];
            end
            // loopback select ignores the on-line bit
            loop0_q <= (mode_nx == `ADTD_MODE_DAC0_LOOP);
            loop1_q <= (mode_nx == `ADTD_MODE_DAC1_LOOP);
        end
    end

    // conversion sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q      <= ADTD_IDLE;
            conv_start_q <= 1'b0;
            result_q     <= 12'h000;
        end else if (ce) begin
            conv_start_q <= start;
            unique case (state_q)
                ADTD_IDLE: begin
                    if (start) begin
                        state_q <= ADTD_BUSY;
                    end
                end
                // result is taken only while a conversion runs
                ADTD_BUSY: begin
                    if (conv_done) begin
                        result_q <= conv_result;
                        state_q  <= ADTD_IDLE;
                    end
                end
            endcase
        end
    end

    // output registers and settle timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac0_q      <= `ADTD_DAC_RESET;
            dac1_q      <= `ADTD_DAC_RESET;
            dac0_load_q <= 1'b0;
            dac1_load_q <= 1'b0;
            settle_q    <= '0;
        end else if (ce) begin
            dac0_load_q <= wr_dac0;
            dac1_load_q <= wr_dac1;
            if (wr_dac0) begin
                dac0_q <= hwdata[11:0];
            end
            if (wr_dac1) begin
                dac1_q <= hwdata[11:0];
            end
            // settling flag stays set until the analog output has caught up, DAC_SETTLE_CYC cycles after a write
            if (wr_dac0 | wr_dac1) begin
                settle_q <= SW'(DAC_SETTLE_CYC);
            end else if (settling) begin
                settle_q <= settle_q - SW'(1);
            end
        end
    end

    // flags and interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q    <= 1'b0;
            irq_st_q   <= `ADTD_IRQ_RESET;
            irq_mask_q <= `ADTD_IRQ_RESET;
            irq_q      <= 1'b0;
        end else if (ce) begin
            ready_q  <= ready_d;
            irq_st_q <= irq_st_d;
            if (wr_imsk) begin
                irq_mask_q <= hwdata[1:0];
            end
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    assign hrdata               = hrdata_q;
    assign hreadyout            = hreadyout_q;
    assign hresp                = hresp_q;
    assign conv_start           = conv_start_q;
    assign adc_chan             = cword_q.chan;
    assign adc_mode             = cword_q.mode;
    assign settle_start         = cword_q.settle_start;
    assign dac0_loopback_select = loop0_q;
    assign dac1_loopback_select = loop1_q;
    assign dac0_code            = dac0_q;
    assign dac1_code            = dac1_q;
    assign dac0_load            = dac0_load_q;
    assign dac1_load            = dac1_load_q;
    assign outputs_online       = online_q;
    assign irq                  = irq_q;
endmodule
`default_nettype wire

/* hw/adtd_pkg.sv */
// types shared by the converter control block
package adtd_pkg;

    typedef enum logic [1:0] {
        ADTD_IDLE,
        ADTD_BUSY
    } adtd_conv_state_t;

    typedef struct packed {
        logic       ext_trig_en;
        logic       signed_format_select;
        logic       settle_start;
        logic       sw_convert_en;
        logic [3:0] mode;
        logic [1:0] rsvd;
        logic [5:0] chan;
    } adtd_cword_t;

    typedef struct packed {
        logic       write_en;
        logic [7:0] addr;
    } adtd_dphase_t;

endpackage

/* hw/adtd_regs.svh */
// register offsets, reset values, mode codes and timing counts of the converter control block
`ifndef ADTD_REGS_SVH
`define ADTD_REGS_SVH

`define ADTD_OFF_CWORD      8'h00
`define ADTD_OFF_STATUS     8'h04
`define ADTD_OFF_DAC0       8'h08
`define ADTD_OFF_DAC1       8'h0C
`define ADTD_OFF_ADC_DATA   8'h10
`define ADTD_OFF_ONLINE     8'h14
`define ADTD_OFF_IRQ_STATUS 8'h18
`define ADTD_OFF_IRQ_MASK   8'h1C

`define ADTD_CWORD_RESET    16'h0000
`define ADTD_CWORD_WMASK    16'hFF3F
`define ADTD_DAC_RESET      12'h000
`define ADTD_IRQ_RESET      2'h0

`define ADTD_MODE_DAC0_LOOP 4'hE
`define ADTD_MODE_DAC1_LOOP 4'hF

`define ADTD_CLK_PERIOD_NS  5
`define ADTD_TRIG_MIN_NS    100
`define ADTD_TRIG_MIN_CYC   ((`ADTD_TRIG_MIN_NS + `ADTD_CLK_PERIOD_NS - 1) / `ADTD_CLK_PERIOD_NS)
`define ADTD_DAC_SETTLE_NS  15000
`define ADTD_DAC_SETTLE_CYC (`ADTD_DAC_SETTLE_NS / `ADTD_CLK_PERIOD_NS)

`endif

/* hw/adtd_sync.sv */
// two-flop synchroniser for levels arriving from pins
`timescale 1ns/1ps
`default_nettype none
module adtd_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else if (ce) begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule
`default_nettype wire

/* hw/adtd_trig_det.sv */
// trigger qualifier: one pulse per low period that lasts the filter length
`timescale 1ns/1ps
`default_nettype none
module adtd_trig_det #(
    parameter int FILT_CYC = 10
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic trig_low,
    output logic      fire
);
    localparam int CW = $clog2(FILT_CYC + 1);

    logic [CW-1:0] cnt_q;
    logic          armed_q;
    logic          fire_q;
    wire           hit = trig_low & armed_q & (cnt_q == CW'(FILT_CYC - 1));

    // rearm only after the line returns high, so one pulse fires once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            armed_q <= 1'b1;
            fire_q  <= 1'b0;
        end else if (ce) begin
            fire_q <= hit;
            if (!trig_low) begin
                cnt_q   <= '0;
                armed_q <= 1'b1;
            end else if (hit) begin
                armed_q <= 1'b0;
            end else if (armed_q) begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end

    assign fire = fire_q;
endmodule
`default_nettype wire

/* sim/adtd_conv_model.sv */
// converter model answering each start after a set latency
`timescale 1ns/1ps
`default_nettype none
module adtd_conv_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [7:0]  lat,
    input  wire logic [11:0] res_in,
    output logic             done,
    output logic      [11:0] result
);
    logic [7:0] cnt_q;
    // result is only valid with done
    assign result = done ? res_in : ~res_in;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            done  <= 1'b0;
        end else begin
            done <= start ? 1'b0 : (cnt_q == 8'h01);
            cnt_q <= start ? lat : (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
        end
    end
endmodule
`default_nettype wire

/* sim/adtd_ctrl_props.sv */
// port checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adtd_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic [3:0]  adc_mode,
    input wire logic        dac0_loopback_select,
    input wire logic        dac1_loopback_select,
    input wire logic [11:0] dac0_code,
    input wire logic [11:0] dac1_code,
    input wire logic        dac0_load,
    input wire logic        dac1_load,
    input wire logic        outputs_online
);
    wire acc  = hsel & hready & htrans[1] & ce;
    wire wr08 = acc & hwrite & (haddr[7:0] == 8'h08);
    wire wr0c = acc & hwrite & (haddr[7:0] == 8'h0C);
    wire wr14 = acc & hwrite & (haddr[7:0] == 8'h14);
    logic busy_q;
    logic rd_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 1'b0;
            rd_q   <= 1'b0;
        end else begin
            busy_q <= conv_start | (busy_q & ~conv_done);
            rd_q   <= acc & ~hwrite;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    resp_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    start_busy_a: assert property (conv_start |-> !busy_q)
        else $error("start while converting");
    dac0_write_a: assert property (wr08 |-> ##2 (dac0_load && dac0_code == $past(hwdata[11:0])))
        else $error("output 0 code wrong after write");
    dac1_write_a: assert property (wr0c |-> ##2 (dac1_load && dac1_code == $past(hwdata[11:0])))
        else $error("output 1 code wrong after write");
    load_cause_a: assert property (dac0_load |-> $past(wr08, 2))
        else $error("output 0 load without write");
    loop_mode_a: assert property ((dac0_loopback_select == (adc_mode == 4'hE))
        && (dac1_loopback_select == (adc_mode == 4'hF)))
        else $error("loopback select disagrees with mode");
    online_write_a: assert property ($changed(outputs_online) |-> $past(wr14, 2))
        else $error("online changed without write");
    rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside data phase");
endmodule
`default_nettype wire

/* sim/test_adc_trigger_dac_output_ctrl.sv */
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_trigger_dac_output_ctrl;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, trig_n = 1'b1, bip = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, x = 32'h620B, d, r;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [11:0] res = 12'h000, conv_result, dac0_code, dac1_code, s;
    logic [7:0]  lat = 8'h05, a;
    logic [31:0] hrdata;
    logic [5:0]  adc_chan;
    logic [3:0]  adc_mode;
    logic        hreadyout, hresp, conv_done, conv_start, settle_start, l0, l1, ld0, ld1, outputs_online, irq;
    int          errors = 0, comparisons = 0, starts = 0, cyc = 0, i;
    always #2.5 hclk = ~hclk;
    adtd_ctrl #(.DAC_SETTLE_CYC(8), .TRIG_FILT_CYC(3)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_n(trig_n),
        .bipolar_range(bip), .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
        .adc_chan(adc_chan), .adc_mode(adc_mode), .settle_start(settle_start), .dac0_loopback_select(l0),
        .dac1_loopback_select(l1), .dac0_code(dac0_code), .dac1_code(dac1_code), .dac0_load(ld0),
        .dac1_load(ld1), .outputs_online(outputs_online), .irq(irq));
    adtd_conv_model i_conv (.clk(hclk), .rst_n(hresetn), .start(conv_start), .lat(lat), .res_in(res),
        .done(conv_done), .result(conv_result));
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    function automatic logic [31:0] exp_adc(logic [11:0] v, logic sg, logic b);
        return (sg & b) ? {16'h0, {5{~v[11]}}, v[10:0]} : {20'h0, v};
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, ad};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, ad, wd, q);
    endtask
    task automatic rdc(input string n, input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, ad, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic wait_rdy();
        logic [31:0] q;
        q = 32'h0;
        for (int k = 0; k < 100 && q[0] !== 1'b1; k++) bus(1'b0, 8'h04, 32'h0, q);
    endtask
    task automatic trig(input int n);
        trig_n <= 1'b0;
        repeat (n) @(posedge hclk);
        trig_n <= 1'b1;
    endtask
    always @(posedge hclk) begin
        if (conv_start === 1'b1) starts++;
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("control word", 8'h00, 32'h0);
        rdc("dac0", 8'h08, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        chk("online pin", 32'h0, {31'h0, outputs_online});
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'hFFFF : (i == 1) ? 32'h0800 : rnd();
            a = i[0] ? 8'h0C : 8'h08;
            wr(a, d);
            rdc("dac readback", a, {20'h0, d[11:0]});
            chk("dac pin", {20'h0, d[11:0]}, {20'h0, i[0] ? dac1_code : dac0_code});
        end
        wr(8'h14, 32'h1);
        rdc("online", 8'h14, 32'h1);
        chk("online pin", 32'h1, {31'h0, outputs_online});
        wr(8'h14, 32'h0);
        for (i = 0; i < 2; i++) begin
            wr(8'h00, 32'h0E00 + (i << 8));
            @(negedge hclk);
            chk("loop select", i + 1, {30'h0, l1, l0});
            chk("online off", 32'h0, {31'h0, outputs_online});
            @(posedge hclk);
        end
        $display("test outputs done");
        wr(8'h1C, 32'h1);
        lat <= 8'd60;
        d = rnd();
        res <= d[11:0];
        wr(8'h00, 32'hA305);
        rdc("control word", 8'h00, 32'hA305);
        chk("channel pin", 32'h5, {26'h0, adc_chan});
        chk("mode pin", 32'h3, {28'h0, adc_mode});
        chk("settle pin", 32'h1, {31'h0, settle_start});
        i = starts;
        trig(20);
        repeat (20) @(posedge hclk);
        chk("one start", i + 1, starts);
        trig(20);
        wait_rdy();
        chk("busy trigger", i + 1, starts);
        rdc("adc data", 8'h10, {20'h0, d[11:0]});
        rdc("irq status", 8'h18, 32'h3);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(8'h18, 32'h3);
        repeat (2) @(negedge hclk);
        chk("irq off", 32'h0, {31'h0, irq});
        @(posedge hclk);
        $display("test trigger done");
        lat <= 8'd3;
        for (i = 0; i < 5; i++) begin
            r = (i == 0) ? 32'h37FF : rnd();
            bip <= r[12];
            res <= r[11:0];
            repeat (3) @(posedge hclk);
            wr(8'h00, 32'h1000 | (r[13] << 14));
            wait_rdy();
            rdc("adc format", 8'h10, exp_adc(r[11:0], r[13], r[12]));
        end
        $display("test format done");
        give_verdict();
    end
endmodule
bind adtd_ctrl adtd_props i_props (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start), .conv_done(conv_done),
    .adc_mode(adc_mode), .dac0_loopback_select(dac0_loopback_select),
    .dac1_loopback_select(dac1_loopback_select), .dac0_code(dac0_code), .dac1_code(dac1_code),
    .dac0_load(dac0_load), .dac1_load(dac1_load), .outputs_online(outputs_online));
`default_nettype wire
